// >>> rtl/dcc_params.svh
`ifndef DCC_PARAMS_SVH
`define DCC_PARAMS_SVH

// register byte addresses
`define DCC_CH0_ADDR      32'hFFFF86CC
`define DCC_CH1_ADDR      32'hFFFF86DC
`define DCC_MASTER_ADDR   32'hFFFF86B0
`define DCC_ZERO32        32'h00000000
`define DCC_RESET_CTRL    19'h00000

// control word field positions
`define DCC_B_ACC_POL     18
`define DCC_B_ACK_PHASE   17
`define DCC_B_ACK_POL     16
`define DCC_B_DST_HI      15
`define DCC_B_DST_LO      14
`define DCC_B_SRC_HI      13
`define DCC_B_SRC_LO      12
`define DCC_B_RSRC_HI     11
`define DCC_B_RSRC_LO     8
`define DCC_B_SENSE       6
`define DCC_B_MODE        5
`define DCC_B_SIZE_HI     4
`define DCC_B_SIZE_LO     3
`define DCC_B_IRQ_EN      2
`define DCC_B_DONE        1
`define DCC_B_EN          0
`define DCC_B_MASTER      0
`define DCC_RSV_HI        31
`define DCC_RSV_LO        19
`define DCC_B_RSV7        7

// request source codes
`define DCC_RS_EXT_DUAL   4'h0
`define DCC_RS_BAD1       4'h1
`define DCC_RS_EXT_S2D    4'h2
`define DCC_RS_EXT_D2S    4'h3
`define DCC_RS_AUTO       4'h4
`define DCC_RS_BAD5       4'h5
`define DCC_RS_TMR0       4'h6
`define DCC_RS_TMR1       4'h7
`define DCC_RS_TMR2       4'h8
`define DCC_RS_BAD9       4'h9
`define DCC_RS_BADA       4'hA
`define DCC_RS_ADC        4'hB
`define DCC_RS_S0TX       4'hC
`define DCC_RS_S0RX       4'hD
`define DCC_RS_S1TX       4'hE
`define DCC_RS_S1RX       4'hF

// address step and unit size codes
`define DCC_STEP_FIX      2'h0
`define DCC_STEP_INC      2'h1
`define DCC_STEP_DEC      2'h2
`define DCC_SIZE_BYTE     2'h0
`define DCC_SIZE_WORD     2'h1
`define DCC_SIZE_LONG     2'h2
`define DCC_MAG_BYTE      4'h1
`define DCC_MAG_WORD      4'h2
`define DCC_MAG_LONG      4'h4
`define DCC_DELTA_ZERO    4'h0

// descriptor routes
`define DCC_ROUTE_DUAL    2'h0
`define DCC_ROUTE_S2D     2'h1
`define DCC_ROUTE_D2S     2'h2
`define DCC_ROUTE_INT     2'h3

`define DCC_FIFO_DEPTH    16

`endif

// >>> rtl/dcc_pkg.sv
package dcc_pkg;

    typedef struct packed {
        logic       accept_polarity;
        logic       ack_phase;
        logic       ack_polarity;
        logic [1:0] dest_step;
        logic [1:0] src_step;
        logic [3:0] request_source;
        logic       request_sense_select;
        logic       transfer_mode;
        logic [1:0] unit_size;
        logic       done_irq_enable;
        logic       count_done_flag;
        logic       channel_enable;
    } dcc_ctrl_type;

    typedef struct packed {
        logic timer0_compare_a_event;
        logic timer1_compare_a_event;
        logic timer2_compare_a_event;
        logic converter_done_event;
        logic serial0_tx_event;
        logic serial0_rx_event;
        logic serial1_tx_event;
        logic serial1_rx_event;
    } dcc_periph_type;

    typedef struct packed {
        logic       channel;
        logic       burst;
        logic [1:0] route;
        logic [1:0] unit_size;
        logic [3:0] src_delta;
        logic [3:0] dst_delta;
        logic       ack_phase;
    } dcc_desc_type;

    typedef struct packed {
        dcc_ctrl_type [1:0] ctrl;
        logic               master_enable;
        logic [1:0]         seen_one;
        logic [1:0]         pin_prev;
        logic [1:0]         edge_held;
        logic [1:0]         pending;
        logic [1:0]         accept;
        logic [1:0]         ack;
        logic [1:0]         irq;
        logic [1:0]         active;
        logic [31:0]        prdata;
        logic               pready;
        logic               pslverr;
    } dcc_state_type;

endpackage

// >>> rtl/dcc_fifo.sv
`timescale 1ns/1ps
module dcc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               rd;
        logic [AW-1:0]               wr;
        logic [AW:0]                 cnt;
    } dcc_fifo_state_type;

    dcc_fifo_state_type st_ff;
    dcc_fifo_state_type nxt_st;
    logic               push;
    logic               pop;

    assign in_ready  = st_ff.cnt != (AW+1)'(DEPTH);
    assign out_valid = st_ff.cnt != '0;
    assign out_data  = st_ff.mem[st_ff.rd];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wr] = in_data;
            nxt_st.wr            = st_ff.wr + 1'b1;
        end
        if (pop) begin
            nxt_st.rd = st_ff.rd + 1'b1;
        end
        if (push && !pop) begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end else if (pop && !push) begin
            nxt_st.cnt = st_ff.cnt - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule

// >>> rtl/dcc_channel_control.sv
// Functional notes
// - each channel control register answers byte, halfword and word writes.
// - bit 18 sets accept strobe polarity, 0 high, 1 low.
// - bit 17 picks read or write cycle for ack; bit 16 its polarity.
// - bits 15:14 step destination fixed, up or down by unit size.
// - bits 13:12 step source fixed, up or down by unit size.
// - source 0000 is external pin dual address; 0001 is prohibited.
// - sources 0010 and 0011 are external single address, each direction.
// - other sources pick auto, timer, converter or serial events; 0101, 1001 and 1010 pick none.
// - bit 6 senses request pin by low level or falling edge.
// - bit 5 picks cycle steal or burst operation.
// - bits 4:3 set unit as byte, halfword or word.
// - bit 2 lets completion raise an interrupt request.
// - done flag set at count end; cleared by 0 after 1 read.
// - bit 0 enables the channel.
// - master enable gates every channel.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "dcc_params.svh"
module dcc_channel_control (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [31:0]             paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic [1:0]              request_input_n,
    input  wire dcc_pkg::dcc_periph_type periph_events,
    input  wire logic [1:0]              count_done,
    input  wire logic [1:0]              unit_done,
    input  wire logic                    standby,
    input  wire logic [1:0]              bus_read_cycle,
    input  wire logic [1:0]              bus_write_cycle,
    output logic [1:0]                   request_accept_strobe,
    output logic [1:0]                   ack_strobe,
    output logic [1:0]                   done_irq,
    output logic [1:0]                   channel_active,
    output logic                         desc_valid,
    input  wire logic                    desc_ready,
    output dcc_pkg::dcc_desc_type        desc_data
);
    dcc_pkg::dcc_state_type st_ff;
    dcc_pkg::dcc_state_type nxt_st;
    dcc_pkg::dcc_desc_type  push_data;
    logic                   push_valid;
    logic                   push_ready;
    logic [1:0]             want;
    logic [1:0]             grant;
    logic [1:0]             trig;
    logic [1:0]             sel_ch;
    logic                   sel_master;
    logic                   xfer;
    logic [31:0]            lane_mask;

    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] ctrl_to_word(
        input dcc_pkg::dcc_ctrl_type c);
        logic [31:0] w;
        w = `DCC_ZERO32;
        w[`DCC_B_ACC_POL]                  = c.accept_polarity;
        w[`DCC_B_ACK_PHASE]                = c.ack_phase;
        w[`DCC_B_ACK_POL]                  = c.ack_polarity;
        w[`DCC_B_DST_HI:`DCC_B_DST_LO]     = c.dest_step;
        w[`DCC_B_SRC_HI:`DCC_B_SRC_LO]     = c.src_step;
        w[`DCC_B_RSRC_HI:`DCC_B_RSRC_LO]   = c.request_source;
        w[`DCC_B_SENSE]                    = c.request_sense_select;
        w[`DCC_B_MODE]                     = c.transfer_mode;
        w[`DCC_B_SIZE_HI:`DCC_B_SIZE_LO]   = c.unit_size;
        w[`DCC_B_IRQ_EN]                   = c.done_irq_enable;
        w[`DCC_B_DONE]                     = c.count_done_flag;
        w[`DCC_B_EN]                       = c.channel_enable;
        return w;
    endfunction
    // done flag is not taken from the word: it has its own set/clear path
    function automatic dcc_pkg::dcc_ctrl_type word_to_ctrl(
        input logic [31:0] w, input logic done);
        dcc_pkg::dcc_ctrl_type c;
        c.accept_polarity      = w[`DCC_B_ACC_POL];
        c.ack_phase            = w[`DCC_B_ACK_PHASE];
        c.ack_polarity         = w[`DCC_B_ACK_POL];
        c.dest_step            = w[`DCC_B_DST_HI:`DCC_B_DST_LO];
        c.src_step             = w[`DCC_B_SRC_HI:`DCC_B_SRC_LO];
        c.request_source       = w[`DCC_B_RSRC_HI:`DCC_B_RSRC_LO];
        c.request_sense_select = w[`DCC_B_SENSE];
        c.transfer_mode        = w[`DCC_B_MODE];
        c.unit_size            = w[`DCC_B_SIZE_HI:`DCC_B_SIZE_LO];
        c.done_irq_enable      = w[`DCC_B_IRQ_EN];
        c.count_done_flag      = done;
        c.channel_enable       = w[`DCC_B_EN];
        return c;
    endfunction
    // prohibited step or size codes give no movement rather than garbage
    function automatic logic [3:0] step_delta(input logic [1:0] step,
                                              input logic [1:0] size);
        logic [3:0] mag;
        mag = `DCC_DELTA_ZERO;
        if (size == `DCC_SIZE_BYTE) begin
            mag = `DCC_MAG_BYTE;
        end else if (size == `DCC_SIZE_WORD) begin
            mag = `DCC_MAG_WORD;
        end else if (size == `DCC_SIZE_LONG) begin
            mag = `DCC_MAG_LONG;
        end
        if (step == `DCC_STEP_INC) begin
            return mag;
        end else if (step == `DCC_STEP_DEC) begin
            return `DCC_DELTA_ZERO - mag;
        end
        return `DCC_DELTA_ZERO;
    endfunction

    ////////////////////////////////////////////////////////////////////
    assign sel_ch[0]  = paddr == `DCC_CH0_ADDR;
    assign sel_ch[1]  = paddr == `DCC_CH1_ADDR;
    assign sel_master = paddr == `DCC_MASTER_ADDR;
    assign xfer       = psel & penable & st_ff.pready;
    assign lane_mask  = {{8{pstrb[3]}}, {8{pstrb[2]}},
                         {8{pstrb[1]}}, {8{pstrb[0]}}};

    always_comb begin
        trig = '0;
        want = '0;
        for (int c = 0; c < 2; c++) begin
            unique case (st_ff.ctrl[c].request_source)
                `DCC_RS_EXT_DUAL, `DCC_RS_EXT_S2D, `DCC_RS_EXT_D2S: begin
                    trig[c] = st_ff.ctrl[c].request_sense_select ?
                              st_ff.edge_held[c] : ~request_input_n[c];
                end
                `DCC_RS_AUTO: trig[c] = 1'b1;
                `DCC_RS_TMR0: trig[c] = periph_events.timer0_compare_a_event;
                `DCC_RS_TMR1: trig[c] = periph_events.timer1_compare_a_event;
                `DCC_RS_TMR2: trig[c] = periph_events.timer2_compare_a_event;
                `DCC_RS_ADC:  trig[c] = periph_events.converter_done_event;
                `DCC_RS_S0TX: trig[c] = periph_events.serial0_tx_event;
                `DCC_RS_S0RX: trig[c] = periph_events.serial0_rx_event;
                `DCC_RS_S1TX: trig[c] = periph_events.serial1_tx_event;
                `DCC_RS_S1RX: trig[c] = periph_events.serial1_rx_event;
                default:      trig[c] = 1'b0;
            endcase
            want[c] = trig[c] & st_ff.active[c] & ~st_ff.pending[c];
        end
    end
    // channel 0 wins a tie; a full queue holds both off
    assign grant[0] = want[0] & push_ready;
    assign grant[1] = want[1] & ~want[0] & push_ready;
    assign push_valid = want[0] | want[1];
    always_comb begin
        int c;
        c = grant[1] ? 1 : 0;
        push_data.channel   = grant[1];
        push_data.burst     = st_ff.ctrl[c].transfer_mode;
        push_data.unit_size = st_ff.ctrl[c].unit_size;
        push_data.src_delta = step_delta(st_ff.ctrl[c].src_step,
                                         st_ff.ctrl[c].unit_size);
        push_data.dst_delta = step_delta(st_ff.ctrl[c].dest_step,
                                         st_ff.ctrl[c].unit_size);
        push_data.ack_phase = st_ff.ctrl[c].ack_phase;
        unique case (st_ff.ctrl[c].request_source)
            `DCC_RS_EXT_DUAL: push_data.route = `DCC_ROUTE_DUAL;
            `DCC_RS_EXT_S2D:  push_data.route = `DCC_ROUTE_S2D;
            `DCC_RS_EXT_D2S:  push_data.route = `DCC_ROUTE_D2S;
            default:          push_data.route = `DCC_ROUTE_INT;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [31:0] img;
        logic        clr;
        img    = `DCC_ZERO32;
        clr    = 1'b0;
        nxt_st = st_ff;
        nxt_st.pready  = psel & penable & ~st_ff.pready;
        nxt_st.pslverr = psel & penable & ~st_ff.pready &
                         ~(sel_ch[0] | sel_ch[1] | sel_master);
        nxt_st.prdata  = `DCC_ZERO32;
        if (psel && penable && !st_ff.pready && !pwrite) begin
            // reserved bits come back as zero
            if (sel_ch[0]) nxt_st.prdata = ctrl_to_word(st_ff.ctrl[0]);
            if (sel_ch[1]) nxt_st.prdata = ctrl_to_word(st_ff.ctrl[1]);
            if (sel_master) nxt_st.prdata[`DCC_B_MASTER] = st_ff.master_enable;
        end
        if (xfer && pwrite && sel_master && pstrb[0]) begin
            nxt_st.master_enable = pwdata[`DCC_B_MASTER];
        end
        for (int c = 0; c < 2; c++) begin
            if (xfer && !pwrite && sel_ch[c] &&
                st_ff.ctrl[c].count_done_flag) begin
                nxt_st.seen_one[c] = 1'b1;
            end
            clr = standby;
            if (xfer && pwrite && sel_ch[c]) begin
                img = (ctrl_to_word(st_ff.ctrl[c]) & ~lane_mask) |
                      (pwdata & lane_mask);
                nxt_st.ctrl[c] = word_to_ctrl(img,
                                              st_ff.ctrl[c].count_done_flag);
                // zero after a one was read
                if (pstrb[0] && !pwdata[`DCC_B_DONE] && st_ff.seen_one[c]) begin
                    clr = 1'b1;
                end
            end
            if (count_done[c]) begin
                nxt_st.ctrl[c].count_done_flag = 1'b1;
            end else if (clr) begin
                nxt_st.ctrl[c].count_done_flag = 1'b0;
                nxt_st.seen_one[c]             = 1'b0;
            end
            nxt_st.pin_prev[c] = request_input_n[c];
            if (st_ff.ctrl[c].request_sense_select &&
                st_ff.pin_prev[c] && !request_input_n[c]) begin
                nxt_st.edge_held[c] = 1'b1;
            end else if (grant[c] || !st_ff.ctrl[c].request_sense_select) begin
                nxt_st.edge_held[c] = 1'b0;
            end
            // cycle steal waits for the unit to end
            if (grant[c] && !st_ff.ctrl[c].transfer_mode) begin
                nxt_st.pending[c] = 1'b1;
            end else if (unit_done[c]) begin
                nxt_st.pending[c] = 1'b0;
            end
            nxt_st.accept[c] = grant[c] ^ nxt_st.ctrl[c].accept_polarity;
            nxt_st.ack[c] = (nxt_st.ctrl[c].ack_phase ? bus_write_cycle[c] :
                             bus_read_cycle[c]) ^ nxt_st.ctrl[c].ack_polarity;
            nxt_st.irq[c] = nxt_st.ctrl[c].count_done_flag &
                            nxt_st.ctrl[c].done_irq_enable;
            nxt_st.active[c] = nxt_st.ctrl[c].channel_enable &
                               nxt_st.master_enable &
                               ~nxt_st.ctrl[c].count_done_flag;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign prdata                = st_ff.prdata;
    assign pready                = st_ff.pready;
    assign pslverr               = st_ff.pslverr;
    assign request_accept_strobe = st_ff.accept;
    assign ack_strobe            = st_ff.ack;
    assign done_irq              = st_ff.irq;
    assign channel_active        = st_ff.active;
    dcc_fifo #(
        .WIDTH ($bits(dcc_pkg::dcc_desc_type)),
        .DEPTH (`DCC_FIFO_DEPTH)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (desc_valid),
        .out_ready (desc_ready),
        .out_data  (desc_data)
    );

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_read_one;
        xfer && !pwrite && sel_ch[0] && st_ff.ctrl[0].count_done_flag;
    endsequence

    apb_wait_state_a: assert property (
        psel && penable && !pready |=> pready)
        else $error("pready not given one cycle into access");
    reserved_read_a: assert property (
        psel && penable && !pwrite && !pready && sel_ch[0] |=>
        prdata[`DCC_RSV_HI:`DCC_RSV_LO] == '0 && !prdata[`DCC_B_RSV7])
        else $error("reserved control bits read nonzero");
    accept_level_a: assert property (
        grant[0] && !st_ff.ctrl[0].accept_polarity &&
        !nxt_st.ctrl[0].accept_polarity |=> request_accept_strobe[0])
        else $error("accept strobe missing");
    ack_read_a: assert property (
        bus_read_cycle[0] && !st_ff.ctrl[0].ack_phase &&
        !st_ff.ctrl[0].ack_polarity && !(xfer && pwrite && sel_ch[0])
        |=> ack_strobe[0])
        else $error("ack strobe missing in read cycle");
    src_step_a: assert property (
        grant[0] && st_ff.ctrl[0].src_step == `DCC_STEP_DEC &&
        st_ff.ctrl[0].unit_size == `DCC_SIZE_LONG |->
        push_data.src_delta == (`DCC_DELTA_ZERO - `DCC_MAG_LONG))
        else $error("source step wrong");
    prohibited_src_a: assert property (
        grant[0] |-> !(st_ff.ctrl[0].request_source inside
        {`DCC_RS_BAD1, `DCC_RS_BAD5, `DCC_RS_BAD9, `DCC_RS_BADA}))
        else $error("prohibited source granted");
    steal_hold_a: assert property (
        grant[0] && !st_ff.ctrl[0].transfer_mode |=>
        !grant[0] ##1 (!grant[0] || $past(unit_done[0])))
        else $error("cycle steal re-granted early");
    flag_set_a: assert property (
        count_done[0] |=> st_ff.ctrl[0].count_done_flag &&
        (done_irq[0] || !st_ff.ctrl[0].done_irq_enable))
        else $error("done flag not set");
    flag_clear_a: assert property (
        $fell(st_ff.ctrl[0].count_done_flag) |->
        $past(standby) || $past(st_ff.seen_one[0]))
        else $error("done flag cleared without read of one");
    gate_grant_a: assert property (
        grant[0] |-> st_ff.master_enable && st_ff.ctrl[0].channel_enable
        && !st_ff.ctrl[0].count_done_flag)
        else $error("grant while gated");
    clear_after_read_a: assert property (
        s_read_one ##[3:4] (xfer && pwrite && sel_ch[0] && pstrb[0] &&
        !pwdata[`DCC_B_DONE] && !count_done[0] && !standby) [*1]
        |=> !st_ff.ctrl[0].count_done_flag)
        else $error("flag not cleared after read then write");
endmodule

// >>> sim/dcc_source_model.sv
`timescale 1ns/1ps
module dcc_source_model (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  req_on,
    input  wire logic                  stall,
    input  wire logic                  desc_valid,
    input  wire dcc_pkg::dcc_desc_type desc_data,
    output logic [1:0]                 request_input_n,
    output dcc_pkg::dcc_periph_type    periph_events,
    output logic                       desc_ready,
    output dcc_pkg::dcc_desc_type      last_desc,
    output logic [7:0]                 got
);
    // pin 0 stays released, so it sits at its pull-up level
    assign request_input_n = {~req_on, 1'h1};
    assign periph_events   = '0;
    assign desc_ready      = ~stall;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_desc <= '0;
            got       <= 8'h00;
        end else if (desc_valid && desc_ready) begin
            last_desc <= desc_data;
            got       <= got + 8'h01;
        end
    end
endmodule

// >>> sim/dcc_channel_control_tb.sv
`timescale 1ns/1ps
`include "dcc_params.svh"
module dcc_channel_control_tb;
    logic                    pclk = 1'h0, presetn = 1'h0, psel = 1'h0;
    logic                    penable = 1'h0, pwrite = 1'h0, err;
    logic [31:0]             paddr = '0, pwdata = '0, prdata, rd;
    logic [3:0]              pstrb = 4'h0;
    logic                    pready, pslverr, standby = 1'h0;
    logic                    req_on = 1'h0, stall = 1'h0;
    logic [1:0]              cnt_done = 2'h0, unit_done = 2'h0;
    logic [1:0]              bus_rd = 2'h0, bus_wr = 2'h0;
    logic [1:0]              req_n, acc, ack, irq, act;
    logic                    desc_valid, desc_ready;
    logic [7:0]              got;
    dcc_pkg::dcc_desc_type   desc_data, last;
    dcc_pkg::dcc_periph_type pev;
    int                      failures = 0, comparisons = 0;

    always #5 pclk = ~pclk;

    dcc_channel_control dcc_channel_control_inst (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .request_input_n(req_n),
        .periph_events(pev), .count_done(cnt_done), .unit_done(unit_done),
        .standby(standby), .bus_read_cycle(bus_rd), .bus_write_cycle(bus_wr),
        .request_accept_strobe(acc), .ack_strobe(ack), .done_irq(irq),
        .channel_active(act), .desc_valid(desc_valid),
        .desc_ready(desc_ready), .desc_data(desc_data));
    dcc_source_model dcc_source_model_inst (.pclk(pclk), .presetn(presetn),
        .req_on(req_on), .stall(stall), .desc_valid(desc_valid),
        .desc_data(desc_data), .request_input_n(req_n),
        .periph_events(pev), .desc_ready(desc_ready), .last_desc(last),
        .got(got));

    task automatic apb(input logic w, input logic [31:0] a, d,
                       input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'h1;
        // the slave answers when it likes; only the watchdog ends a wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic chk(input logic [31:0] g, e, input string m);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("FAIL %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic wait_got(input logic [7:0] n);
        for (int i = 0; i < 30 && got !== n; i++) @(posedge pclk);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        tally_and_finish();
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, `DCC_CH0_ADDR, '0, 4'h0);
        chk(rd, 32'h00000000, "ch0 reset");
        apb(1'h1, `DCC_CH0_ADDR, 32'hFFF79FF6, 4'hF);
        apb(1'h0, `DCC_CH0_ADDR, '0, 4'h0);
        chk(rd, 32'h00079F74, "ch0 mask");
        chk({30'h0, acc}, 32'h00000001, "accept idle low");
        chk({30'h0, ack}, 32'h00000001, "ack idle low");
        apb(1'h1, `DCC_CH1_ADDR, 32'hFFFFFF75, 4'h1);
        apb(1'h0, `DCC_CH1_ADDR, '0, 4'h0);
        chk(rd, 32'h00000075, "ch1 byte lane");
        apb(1'h0, 32'hFFFF8000, '0, 4'h0);
        chk({31'h0, err}, 32'h00000001, "unmapped");
        $display("test registers done");
        apb(1'h1, `DCC_CH1_ADDR, 32'h00000000, 4'hF);
        apb(1'h1, `DCC_CH0_ADDR, 32'h0000940D, 4'hF);
        repeat (5) @(posedge pclk);
        chk({24'h0, got}, 32'h00000000, "master off");
        apb(1'h1, `DCC_MASTER_ADDR, 32'h00000001, 4'hF);
        wait_got(8'h01);
        chk({17'h0, last}, {17'h0, 15'h1A5C}, "auto desc");
        chk({30'h0, act}, 32'h00000001, "active");
        bus_rd <= 2'h1;
        repeat (2) @(posedge pclk);
        chk({30'h0, ack}, 32'h00000001, "ack read phase");
        bus_rd <= 2'h0;
        cnt_done <= 2'h1;
        unit_done <= 2'h1;
        @(posedge pclk);
        cnt_done <= 2'h0;
        unit_done <= 2'h0;
        apb(1'h0, `DCC_CH0_ADDR, '0, 4'h0);
        chk(rd, 32'h0000940F, "done set");
        chk({30'h0, irq}, 32'h00000001, "done irq");
        chk({24'h0, got}, 32'h00000001, "no grant when done");
        apb(1'h1, `DCC_CH0_ADDR, 32'h0000940D, 4'hF);
        apb(1'h0, `DCC_CH0_ADDR, '0, 4'h0);
        chk(rd, 32'h0000940D, "done clear");
        chk({24'h0, got}, 32'h00000002, "regrant after clear");
        $display("test auto request done");
        stall <= 1'h1;
        apb(1'h1, `DCC_CH1_ADDR, 32'h00000001, 4'hF);
        req_on <= 1'h1;
        repeat (4) @(posedge pclk);
        chk({24'h0, got}, 32'h00000002, "stalled");
        stall <= 1'h0;
        wait_got(8'h03);
        chk({17'h0, last}, {17'h0, 15'h4000}, "pin desc");
        req_on <= 1'h0;
        $display("test external request done");
        apb(1'h1, `DCC_CH1_ADDR, 32'h00000041, 4'hF);
        unit_done <= 2'h2;
        @(posedge pclk);
        unit_done <= 2'h0;
        repeat (3) @(posedge pclk);
        chk({24'h0, got}, 32'h00000003, "no edge no grant");
        req_on <= 1'h1;
        wait_got(8'h04);
        chk({24'h0, got}, 32'h00000004, "edge grant");
        unit_done <= 2'h2;
        @(posedge pclk);
        unit_done <= 2'h0;
        repeat (4) @(posedge pclk);
        chk({24'h0, got}, 32'h00000004, "one grant per edge");
        $display("test edge request done");
        tally_and_finish();
    end
endmodule
